// [pgc_command_path.sv]
// command path of a streaming pattern generator: registers, command
// queue and segment sender
// assumes software on a plain register port and a sink that gives ready
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - two 32-bit command words at offsets 0,1
// - push to queue only on low word write
// - low bits 15:0 give segment symbol count
// - non-final segments padded to whole beats
// - channel from low bits of field 29:16
// - bit 30 marks first segment, packet-only
// - bit 31 marks final segment, packet-only
// - high bits 15:0 drive error output
// - data XORed with mask bits 23:16
// - bit 24 hides start of packet
// - bit 25 hides end of packet
// - fill bits 15:7 show queued command count
// - busy while sending or commands queued
module pgc_command_path #(
    parameter int SYMBOLS_PER_BEAT = 4,
    parameter int SYMBOL_WIDTH = 8,
    parameter int CHANNEL_WIDTH = 8,
    parameter int QUEUE_DEPTH = 8,
    parameter bit SUPPORT_PACKETS = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // streaming source
    output logic srcValid,
    input wire logic srcReady,
    output logic [SYMBOLS_PER_BEAT*SYMBOL_WIDTH-1:0] srcData,
    output logic [CHANNEL_WIDTH-1:0] srcChannel,
    output logic [15:0] srcError,
    output logic srcStartOfPacket,
    output logic srcEndOfPacket,
    output logic [$clog2(SYMBOLS_PER_BEAT+1)-1:0] srcEmpty,
    // status
    output logic busy
);
    localparam int DW = SYMBOLS_PER_BEAT * SYMBOL_WIDTH;
    localparam int CW = $bits(pgc_pkg::pgc_cmd_t);
    localparam int QCW = $clog2(QUEUE_DEPTH + 1);
    localparam int EW = $clog2(SYMBOLS_PER_BEAT + 1);
    initial
    begin
        if (CHANNEL_WIDTH < 1 || CHANNEL_WIDTH > 14)
            $error("channel width must be 1 to 14");
        if (SYMBOLS_PER_BEAT < 1 || SYMBOL_WIDTH < 8)
            $error("need at least one symbol of at least 8 bits");
        if (QCW > 9)
            $error("queue depth too large for fill field");
    end

    logic [31:0] cmdLo_r;
    logic [31:0] cmdHi_r;
    pgc_pkg::pgc_cmd_t pushCmd;
    pgc_pkg::pgc_cmd_t headCmd;
    pgc_pkg::pgc_cmd_t cur_r;
    logic [CW-1:0] headBits;
    logic qInReady;
    logic qOutValid;
    logic qOutReady;
    logic [QCW-1:0] qCount;
    logic loWrite;
    pgc_pkg::pgc_state_t state_r;
    logic [16:0] left_r;
    logic firstBeat_r;
    logic [7:0] pattern_r;
    logic beatTaken;
    logic lastBeat;
    logic [16:0] beatSyms;
    logic [DW-1:0] rawData;
    logic [DW-1:0] maskWide;

    // registers
    assign loWrite = regWr && (regAddr == pgc_pkg::ADDR_COMMAND_LOW_WORD);
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cmdLo_r <= pgc_pkg::REG_RESET;
            cmdHi_r <= pgc_pkg::REG_RESET;
        end
        else if (regWr)
        begin
            if (regAddr == pgc_pkg::ADDR_COMMAND_LOW_WORD)
                cmdLo_r <= regWrData;
            if (regAddr == pgc_pkg::ADDR_COMMAND_HIGH_WORD)
                cmdHi_r <= regWrData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            regRdData <= '0;
        else if (regRd)
        begin
            unique case (regAddr)
                pgc_pkg::ADDR_COMMAND_LOW_WORD: regRdData <= cmdLo_r;
                pgc_pkg::ADDR_COMMAND_HIGH_WORD: regRdData <= cmdHi_r;
                pgc_pkg::ADDR_FILL:
                begin
                    regRdData <= '0;
                    regRdData[pgc_pkg::BUSY_BIT] <= busy;
                    regRdData[pgc_pkg::FILL_LSB +: QCW] <= qCount;
                end
                default: regRdData <= '0;
            endcase
        end
    end

    // the pushed command takes the fresh low word and the stored high word
    always_comb
    begin
        pushCmd.size = regWrData[pgc_pkg::SIZE_LSB +: 16];
        pushCmd.channel = regWrData[pgc_pkg::CHAN_LSB +: 14];
        pushCmd.firstSeg = regWrData[pgc_pkg::FIRST_BIT]
            && SUPPORT_PACKETS;
        pushCmd.finalSeg = regWrData[pgc_pkg::FINAL_BIT]
            && SUPPORT_PACKETS;
        pushCmd.errVal = cmdHi_r[pgc_pkg::ERR_LSB +: 16];
        pushCmd.mask = cmdHi_r[pgc_pkg::MASK_LSB +: 8];
        pushCmd.hideStart = cmdHi_r[pgc_pkg::HIDE_START_BIT];
        pushCmd.hideEnd = cmdHi_r[pgc_pkg::HIDE_END_BIT];
    end

    // a write while the queue is full is dropped; software reads fill first
    pgc_fifo #(
        .WIDTH(CW),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .clk(clk),
        .nrst(nrst),
        .inValid(loWrite),
        .inReady(qInReady),
        .inData(pushCmd),
        .outValid(qOutValid),
        .outReady(qOutReady),
        .outData(headBits),
        .count(qCount)
    );
    assign headCmd = pgc_pkg::pgc_cmd_t'(headBits);
    assign qOutReady = (state_r == pgc_pkg::PGC_IDLE);

    // segment sender
    assign beatTaken = srcValid && srcReady;
    assign lastBeat = (left_r <= 17'(SYMBOLS_PER_BEAT));
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= pgc_pkg::PGC_IDLE;
            cur_r <= '0;
            left_r <= '0;
            firstBeat_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                pgc_pkg::PGC_IDLE:
                begin
                    if (qOutValid)
                    begin
                        cur_r <= headCmd;
                        left_r <= {1'b0, headCmd.size};
                        firstBeat_r <= 1'b1;
                        state_r <= pgc_pkg::PGC_SEND;
                    end
                end
                pgc_pkg::PGC_SEND:
                begin
                    if (beatTaken)
                    begin
                        firstBeat_r <= 1'b0;
                        if (lastBeat)
                        begin
                            left_r <= '0;
                            state_r <= pgc_pkg::PGC_IDLE;
                        end
                        else
                            left_r <= left_r - 17'(SYMBOLS_PER_BEAT);
                    end
                end
            endcase
        end
    end

    // incrementing byte pattern, one count per symbol
    always_ff @(posedge clk)
    begin
        if (!nrst)
            pattern_r <= '0;
        else if (beatTaken)
            pattern_r <= pattern_r + 8'(SYMBOLS_PER_BEAT);
    end

    genvar s;
    generate
        for (s = 0; s < SYMBOLS_PER_BEAT; s = s + 1)
        begin : g_sym
            assign rawData[(SYMBOLS_PER_BEAT-1-s)*SYMBOL_WIDTH +: SYMBOL_WIDTH]
                = SYMBOL_WIDTH'(pattern_r + 8'(s));
            assign maskWide[s*SYMBOL_WIDTH +: SYMBOL_WIDTH]
                = SYMBOL_WIDTH'(cur_r.mask);
        end
    endgenerate

    // a zero-size segment still sends one beat so the command completes
    assign beatSyms = lastBeat ? left_r : 17'(SYMBOLS_PER_BEAT);
    assign srcValid = (state_r == pgc_pkg::PGC_SEND);
    assign srcData = rawData ^ maskWide;
    assign srcChannel = cur_r.channel[CHANNEL_WIDTH-1:0];
    assign srcError = cur_r.errVal;
    assign srcStartOfPacket = srcValid && firstBeat_r && cur_r.firstSeg
        && !cur_r.hideStart;
    assign srcEndOfPacket = srcValid && lastBeat && cur_r.finalSeg
        && !cur_r.hideEnd;
    // padding: only the final segment may end on a partial beat
    assign srcEmpty = (srcValid && lastBeat && cur_r.finalSeg
        && beatSyms != 17'd0)
        ? EW'(17'(SYMBOLS_PER_BEAT) - beatSyms) : '0;
    assign busy = srcValid || qOutValid;

    property p_push_count;
        @(posedge clk) disable iff (!nrst)
        (loWrite && qInReady && !qOutReady) |=> qCount == $past(qCount) + 1;
    endproperty
    a_push_count: assert property (p_push_count)
        else $error("low word write did not enter the queue");

    property p_hi_no_push;
        @(posedge clk) disable iff (!nrst)
        (regWr && regAddr == pgc_pkg::ADDR_COMMAND_HIGH_WORD && !qOutReady)
        |=> qCount == $past(qCount);
    endproperty
    a_hi_no_push: assert property (p_hi_no_push)
        else $error("high word write changed queue fill");

    property p_busy;
        @(posedge clk) disable iff (!nrst)
        (qCount != '0 || state_r == pgc_pkg::PGC_SEND) |-> busy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy low while work pending");

    property p_hide_start;
        @(posedge clk) disable iff (!nrst)
        cur_r.hideStart |-> !srcStartOfPacket;
    endproperty
    a_hide_start: assert property (p_hide_start)
        else $error("start asserted while hidden");

    property p_hide_end;
        @(posedge clk) disable iff (!nrst)
        cur_r.hideEnd |-> !srcEndOfPacket;
    endproperty
    a_hide_end: assert property (p_hide_end)
        else $error("end asserted while hidden");

    property p_pad;
        @(posedge clk) disable iff (!nrst)
        (srcValid && !cur_r.finalSeg) |-> srcEmpty == '0;
    endproperty
    a_pad: assert property (p_pad)
        else $error("non-final segment ended on partial beat");

    property p_take;
        @(posedge clk) disable iff (!nrst)
        (state_r == pgc_pkg::PGC_IDLE && qOutValid)
        |=> srcValid && cur_r == $past(headCmd);
    endproperty
    a_take: assert property (p_take)
        else $error("head command not taken in order");

    property p_err;
        @(posedge clk) disable iff (!nrst)
        srcValid |-> srcError == cur_r.errVal;
    endproperty
    a_err: assert property (p_err)
        else $error("error output differs from command");

    // beats taken in the current segment, judged against its size field
    logic [16:0] segBeats_r;
    logic [16:0] wantBeats;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            segBeats_r <= '0;
        else if (state_r == pgc_pkg::PGC_IDLE)
            segBeats_r <= '0;
        else if (beatTaken)
            segBeats_r <= segBeats_r + 17'h1;
    end
    assign wantBeats = (cur_r.size == 16'h0) ? 17'h1
        : 17'(({1'b0, cur_r.size} + 17'(SYMBOLS_PER_BEAT - 1))
        / 17'(SYMBOLS_PER_BEAT));

    property p_seg_beats;
        @(posedge clk) disable iff (!nrst)
        (beatTaken && lastBeat) |-> segBeats_r + 17'h1 == wantBeats;
    endproperty
    a_seg_beats: assert property (p_seg_beats)
        else $error("segment beat count differs from size");

    property p_start_first;
        @(posedge clk) disable iff (!nrst)
        srcStartOfPacket |-> segBeats_r == '0;
    endproperty
    a_start_first: assert property (p_start_first)
        else $error("start marked on a later beat");

    property p_end_last;
        @(posedge clk) disable iff (!nrst)
        srcEndOfPacket |-> segBeats_r + 17'h1 == wantBeats;
    endproperty
    a_end_last: assert property (p_end_last)
        else $error("end marked before the last beat");

    property p_idle_gap;
        @(posedge clk) disable iff (!nrst)
        (beatTaken && lastBeat) |=> !srcValid;
    endproperty
    a_idle_gap: assert property (p_idle_gap)
        else $error("next segment started without a gap");

    property p_stall_hold;
        @(posedge clk) disable iff (!nrst)
        (srcValid && !srcReady) |=> srcValid && $stable(srcData)
            && $stable(srcChannel) && $stable(srcError)
            && $stable(srcStartOfPacket) && $stable(srcEndOfPacket)
            && $stable(srcEmpty);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("beat changed while stalled");

    property p_full_drop;
        @(posedge clk) disable iff (!nrst)
        (loWrite && !qInReady && !qOutReady) |=> qCount == $past(qCount);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("push into a full queue changed fill");

    property p_fill_read;
        @(posedge clk) disable iff (!nrst)
        (regRd && regAddr == pgc_pkg::ADDR_FILL)
        |=> regRdData[pgc_pkg::FILL_LSB +: QCW] == $past(qCount)
            && regRdData[pgc_pkg::BUSY_BIT] == $past(busy);
    endproperty
    a_fill_read: assert property (p_fill_read)
        else $error("fill read differs from queue state");
endmodule : pgc_command_path

// [pgc_pkg.sv]
// package for the pattern generator command path: register map, fields
// assumes a plain register port and one clock domain
package pgc_pkg;
    localparam logic [1:0] ADDR_COMMAND_LOW_WORD = 2'h0;
    localparam logic [1:0] ADDR_COMMAND_HIGH_WORD = 2'h1;
    localparam logic [1:0] ADDR_FILL = 2'h2;
    localparam int SIZE_LSB = 0;
    localparam int CHAN_LSB = 16;
    localparam int FIRST_BIT = 30;
    localparam int FINAL_BIT = 31;
    localparam int ERR_LSB = 0;
    localparam int MASK_LSB = 16;
    localparam int HIDE_START_BIT = 24;
    localparam int HIDE_END_BIT = 25;
    localparam int BUSY_BIT = 0;
    localparam int FILL_LSB = 7;
    localparam logic [31:0] REG_RESET = 32'h0;

    typedef struct packed {
        logic [15:0] size;
        logic [13:0] channel;
        logic firstSeg;
        logic finalSeg;
        logic [15:0] errVal;
        logic [7:0] mask;
        logic hideStart;
        logic hideEnd;
    } pgc_cmd_t;

    typedef enum logic [0:0] {
        PGC_IDLE,
        PGC_SEND
    } pgc_state_t;
endpackage : pgc_pkg

// [pgc_fifo.sv]
// synchronous valid/ready fifo for commands
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module pgc_fifo #(
    parameter int WIDTH = 58,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // occupancy
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int NW = $clog2(DEPTH + 1);
    localparam logic [NW-1:0] FULL = NW'(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("pgc_fifo depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [$clog2(DEPTH+1)-1:0] count_r;
    logic push;
    logic pop;
    assign inReady = (count_r != FULL);
    assign outValid = (count_r != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_r];
    assign count = count_r;
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_r] <= inData;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (pop)
                rdPtr_r <= rdPtr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule : pgc_fifo

// [pgc_sink_model.sv]
// stream sink standing in for a pattern checker: drives ready only
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module pgc_sink_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // test controls
    input wire logic hold,
    input wire logic slow,
    // stream
    output logic ready
);
    // slow mode stalls every other cycle so beats must hold their values
    always_ff @(posedge clk)
    begin
        if (!nrst || hold)
            ready <= 1'b0;
        else if (slow)
            ready <= ~ready;
        else
            ready <= 1'b1;
    end
endmodule : pgc_sink_model

// [tb_pgc_command_path.sv]
// testbench for the pattern generator command path
// assumes pgc_pkg, pgc_fifo, the design and the sink model compiled first
`timescale 1ns/1ps
module tb_pgc_command_path;
    logic clk, nrst, regWr, regRd, srcReady, srcValid, busy, hold, slow;
    logic [1:0] regAddr;
    logic [31:0] regWrData, regRdData, srcData;
    logic [7:0] srcChannel, pc;
    logic [15:0] srcError;
    logic srcStartOfPacket, srcEndOfPacket;
    logic [2:0] srcEmpty;
    int n_fail, n_tests;

    pgc_command_path pgc_command_path_inst (.clk(clk), .nrst(nrst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .srcValid(srcValid),
        .srcReady(srcReady), .srcData(srcData), .srcChannel(srcChannel),
        .srcError(srcError), .srcStartOfPacket(srcStartOfPacket),
        .srcEndOfPacket(srcEndOfPacket), .srcEmpty(srcEmpty), .busy(busy));
    pgc_sink_model pgc_sink_model_inst (.clk(clk), .nrst(nrst),
        .hold(hold), .slow(slow), .ready(srcReady));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [1:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("read data", regRdData, exp);
    endtask : rd

    // high word first: only the low word write pushes the command
    task automatic cmd(input logic [31:0] hi, lo);
        wr(2'h1, hi);
        wr(2'h0, lo);
    endtask : cmd

    // waits for one accepted beat and judges every field of it
    task automatic beat(input logic [7:0] m, input logic [15:0] e,
        input logic [7:0] ch, input logic s, f, input logic [2:0] emp);
        logic [31:0] d;
        int i;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end
        while (!(srcValid === 1'b1 && srcReady === 1'b1) && i < 200);
        if (!(srcValid === 1'b1 && srcReady === 1'b1))
        begin
            n_fail++;
            final_report();
        end
        for (i = 0; i < 4; i++)
            d[31-8*i -: 8] = (pc + 8'(i)) ^ m;
        pc = pc + 8'h4;
        chk("data", srcData, d);
        chk("channel", {24'h0, srcChannel}, {24'h0, ch});
        chk("error", {16'h0, srcError}, {16'h0, e});
        chk("start", {31'h0, srcStartOfPacket}, {31'h0, s});
        chk("end", {31'h0, srcEndOfPacket}, {31'h0, f});
        chk("empty", {29'h0, srcEmpty}, {29'h0, emp});
        @(posedge clk);
    endtask : beat

    task automatic t_reset;
        chk("valid", {31'h0, srcValid}, 32'h0);
        chk("busy", {31'h0, busy}, 32'h0);
        rd(2'h2, 32'h0);
        rd(2'h0, 32'h0);
        rd(2'h1, 32'h0);
        wr(2'h3, 32'hffff_ffff);
        rd(2'h3, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_single;
        cmd(32'h005a_0005, 32'hc3ab_0006);
        beat(8'h5a, 16'h5, 8'hab, 1'b1, 1'b0, 3'h0);
        beat(8'h5a, 16'h5, 8'hab, 1'b0, 1'b1, 3'h2);
        rd(2'h1, 32'h005a_0005);
        rd(2'h0, 32'hc3ab_0006);
        $display("test single done");
    endtask : t_single

    task automatic t_pad;
        slow <= 1'b1;
        cmd(32'h0, 32'h4001_0006);
        beat(8'h0, 16'h0, 8'h01, 1'b1, 1'b0, 3'h0);
        beat(8'h0, 16'h0, 8'h01, 1'b0, 1'b0, 3'h0);
        cmd(32'h0, 32'h8001_0004);
        beat(8'h0, 16'h0, 8'h01, 1'b0, 1'b1, 3'h0);
        slow <= 1'b0;
        $display("test padding done");
    endtask : t_pad

    task automatic t_hide;
        cmd(32'h0300_0000, 32'hc002_0004);
        @(negedge clk);
        chk("busy", {31'h0, busy}, 32'h1);
        beat(8'h0, 16'h0, 8'h02, 1'b0, 1'b0, 3'h0);
        $display("test hide done");
    endtask : t_hide

    // one command sits in the sender, eight fill the queue, the tenth drops
    task automatic t_queue;
        int i;
        hold <= 1'b1;
        for (i = 0; i < 10; i++)
            cmd({16'h0, 16'(i + 1)}, 32'hc007_0004);
        @(negedge clk);
        chk("busy", {31'h0, busy}, 32'h1);
        rd(2'h2, 32'h0000_0401);
        hold <= 1'b0;
        slow <= 1'b1;
        for (i = 0; i < 9; i++)
            beat(8'h0, 16'(i + 1), 8'h07, 1'b1, 1'b1, 3'h0);
        rd(2'h2, 32'h0);
        chk("busy", {31'h0, busy}, 32'h0);
        slow <= 1'b0;
        $display("test queue done");
    endtask : t_queue

    initial
    begin
        nrst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 2'h0;
        regWrData = 32'h0;
        hold = 1'b0;
        slow = 1'b0;
        pc = 8'h0;
        n_fail = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_single();
        t_pad();
        t_hide();
        t_queue();
        final_report();
    end
endmodule : tb_pgc_command_path
